// [hw/pes_counter.sv]
// pes_counter: one event counter with software load and wrap pulse
// assumes the increment is already qualified by the select logic
module pes_counter #(
    parameter int W = 32,
    parameter int IW = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [IW-1:0] inc,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic [W-1:0] count,
    output logic wrap
);
    import pes_pkg::*;

    logic [W-1:0] count_reg;
    logic [W:0] sum;

    assign sum = {1'b0, count_reg} + {{(W + 1 - IW){1'b0}}, inc};
    // a software load wins over a same-cycle increment
    assign wrap = enable && !load && sum[W];
    assign count = count_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= CTR_RESET[W-1:0];
        end else if (load) begin
            count_reg <= load_value;
        end else if (enable) begin
            count_reg <= sum[W-1:0];
        end
    end
endmodule

// [hw/pes_evt_match.sv]
// pes_evt_match: turns one event select into a per-cycle increment
// assumes event inputs are synchronous counts or pulses from the core
module pes_evt_match #(
    parameter int EW = 2,
    parameter int IW = 4
) (
    input wire logic [7:0] code,
    input wire logic [7:0] umask,
    input wire logic [EW-1:0] simd_instr_executed_evt,
    input wire logic [EW-1:0] simd_move_store_evt,
    input wire logic [EW-1:0] simd_saturating_executed_evt,
    input wire logic [EW-1:0] simd_microop_executed_evt,
    input wire logic [pes_pkg::UM_KIND_W-1:0] simd_instr_kind_evt,
    input wire logic simd_to_float_evt,
    input wire logic float_to_simd_evt,
    input wire logic simd_assist_evt,
    input wire logic [EW-1:0] simd_instr_retired_evt,
    input wire logic [3:0] segment_rename_stall_evt,
    input wire logic [3:0] segment_rename_count_evt,
    input wire logic [EW-1:0] segment_rename_retired_evt,
    input wire logic cache_evt_valid,
    input wire logic [7:0] cache_evt_code,
    input wire logic [pes_pkg::UM_STATE_W-1:0] cache_evt_state,
    input wire logic bus_evt_valid,
    input wire logic [7:0] bus_evt_code,
    input wire logic bus_evt_self,
    output logic [IW-1:0] inc
);
    import pes_pkg::*;

    function automatic logic [IW-1:0] ones(input logic [7:0] v);
        logic [IW-1:0] n;
        n = '0;
        for (int i = 0; i < 8; i++) begin
            n = n + IW'(v[i]);
        end
        return ones_ret(n);
    endfunction

    function automatic logic [IW-1:0] ones_ret(input logic [IW-1:0] n);
        return n;
    endfunction

    wire logic um_none = (umask == UM_NONE);
    // stores of the move instructions are reported separately and taken out
    wire logic [EW-1:0] exec_net = (simd_instr_executed_evt > simd_move_store_evt) ?
        simd_instr_executed_evt - simd_move_store_evt : '0;
    // a zero state mask matches no line state, so no cache event counts
    wire logic cache_hit = cache_evt_valid && cache_evt_code == code &&
        |(cache_evt_state & umask[UM_STATE_W-1:0]);
    wire logic bus_hit = bus_evt_valid && bus_evt_code == code &&
        (bus_evt_self || umask[UM_ANY_AGENT_BIT]);

    always_comb begin
        inc = '0;
        case (code)
            EV_SIMD_EXEC: inc = um_none ? IW'(exec_net) : '0;
            EV_SIMD_SAT: inc = um_none ? IW'(simd_saturating_executed_evt) : '0;
            EV_SIMD_UOP: inc = (umask == UM_UOP_ALL) ?
                IW'(simd_microop_executed_evt) : '0;
            EV_SIMD_KIND: inc = ones({2'h0, simd_instr_kind_evt & umask[5:0]});
            EV_FP_TRANS: inc = um_none ? IW'(simd_to_float_evt) :
                (umask == UM_TO_SIMD) ? IW'(float_to_simd_evt) : '0;
            EV_SIMD_ASSIST: inc = um_none ? IW'(simd_assist_evt) : '0;
            EV_SIMD_RET: inc = um_none ? IW'(simd_instr_retired_evt) : '0;
            EV_SEG_STALL: inc = ones({4'h0, segment_rename_stall_evt & umask[3:0]});
            // bit 3 taken as the fourth segment register
            EV_SEG_REN: inc = ones({4'h0, segment_rename_count_evt & umask[3:0]});
            EV_SEG_RET: inc = um_none ? IW'(segment_rename_retired_evt) : '0;
            default: inc = IW'(cache_hit) + IW'(bus_hit);
        endcase
    end
endmodule

// [hw/pes_top.sv]
// pes_top: two event selects and counters for simd and segment events
// Function
// - B0/00 counts simd executed, move stores excluded
// - B1/00 counts saturating simd instructions executed
// - B2/0F counts simd micro-ops executed
// - B3 counts simd instructions by mask-selected kind
// - CC counts simd/float transitions, mask picks direction
// - CD/00 counts simd assists
// - CE/00 counts simd instructions at retirement
// - D4 counts rename stalls of masked segments
// - D5 counts renames of masked segment registers
// - D6/00 counts retired segment rename events
// - cache events qualified by low mask nibble
// - mask bits 3..0 select M, E, S, I
// - zero state mask counts no cache events; bus events still count
// - bus events qualified by each select's own mask
// - mask bit 5 picks self or any agent
// assumes AXI4-Lite master, core event inputs synchronous to sys_clk
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
module pes_top #(
    parameter int EW = 2,
    parameter int IW = 4,
    parameter int CW = 32
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [pes_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pes_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [EW-1:0] simd_instr_executed_evt,
    input wire logic [EW-1:0] simd_move_store_evt,
    input wire logic [EW-1:0] simd_saturating_executed_evt,
    input wire logic [EW-1:0] simd_microop_executed_evt,
    input wire logic [pes_pkg::UM_KIND_W-1:0] simd_instr_kind_evt,
    input wire logic simd_to_float_evt,
    input wire logic float_to_simd_evt,
    input wire logic simd_assist_evt,
    input wire logic [EW-1:0] simd_instr_retired_evt,
    input wire logic [3:0] segment_rename_stall_evt,
    input wire logic [3:0] segment_rename_count_evt,
    input wire logic [EW-1:0] segment_rename_retired_evt,
    input wire logic cache_evt_valid,
    input wire logic [7:0] cache_evt_code,
    input wire logic [pes_pkg::UM_STATE_W-1:0] cache_evt_state,
    input wire logic bus_evt_valid,
    input wire logic [7:0] bus_evt_code,
    input wire logic bus_evt_self
);
    import pes_pkg::*;

    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] sel_reg [2];
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [CW-1:0] ctr [2];
    logic [1:0] wrap;
    logic [IW-1:0] inc [2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // write side: address and data may arrive in either order
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_reg;
    wire logic [31:0] wr_data = w_take ? s_axi_wdata : wdata_reg;
    wire logic [3:0] wr_strb = w_take ? s_axi_wstrb : wstrb_reg;
    wire logic wr_go = (aw_take || aw_held_reg) && (w_take || w_held_reg);
    wire logic wr_sel0 = wr_go && wr_addr == ADDR_SEL0;
    wire logic wr_sel1 = wr_go && wr_addr == ADDR_SEL1;
    wire logic wr_ctr0 = wr_go && wr_addr == ADDR_CTR0;
    wire logic wr_ctr1 = wr_go && wr_addr == ADDR_CTR1;
    wire logic wr_stat = wr_go && wr_addr == ADDR_STATUS;
    wire logic wr_hit = wr_sel0 || wr_sel1 || wr_ctr0 || wr_ctr1 || wr_stat;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else begin
            aw_held_reg <= (aw_held_reg || aw_take) && !wr_go;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            w_held_reg <= (w_held_reg || w_take) && !wr_go;
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // event selects steer the matchers; cleared selects count nothing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_reg[0] <= SEL_RESET;
            sel_reg[1] <= SEL_RESET;
        end else begin
            if (wr_sel0) begin
                sel_reg[0] <= merge(sel_reg[0], wr_data, wr_strb);
            end
            if (wr_sel1) begin
                sel_reg[1] <= merge(sel_reg[1], wr_data, wr_strb);
            end
        end
    end

    // wrap flags: write one clears, a wrap in the same cycle wins
    assign status_next = (status_reg & ~(wr_stat ? wr_data[1:0] & {2{wr_strb[0]}} : 2'h0))
        | wrap;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // read side: one-cycle registered answer, slave error off the map
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic rd_sel0 = s_axi_araddr == ADDR_SEL0;
    wire logic rd_sel1 = s_axi_araddr == ADDR_SEL1;
    wire logic rd_ctr0 = s_axi_araddr == ADDR_CTR0;
    wire logic rd_ctr1 = s_axi_araddr == ADDR_CTR1;
    wire logic rd_stat = s_axi_araddr == ADDR_STATUS;
    wire logic rd_hit = rd_sel0 || rd_sel1 || rd_ctr0 || rd_ctr1 || rd_stat;
    wire logic [31:0] rd_mux = rd_sel0 ? sel_reg[0] :
                               rd_sel1 ? sel_reg[1] :
                               rd_ctr0 ? 32'(ctr[0]) :
                               rd_ctr1 ? 32'(ctr[1]) :
                               rd_stat ? {30'h0, status_reg} : 32'h0;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // one matcher and counter per select; both qualify by their own mask
    for (genvar g = 0; g < 2; g++) begin : g_chan
        wire logic [31:0] sel = sel_reg[g];
        wire logic ld = (g == 0) ? wr_ctr0 : wr_ctr1;

        pes_evt_match #(.EW(EW), .IW(IW)) u_match (
            .code(sel[SEL_CODE_LSB +: 8]),
            .umask(sel[SEL_UM_LSB +: 8]),
            .simd_instr_executed_evt(simd_instr_executed_evt),
            .simd_move_store_evt(simd_move_store_evt),
            .simd_saturating_executed_evt(simd_saturating_executed_evt),
            .simd_microop_executed_evt(simd_microop_executed_evt),
            .simd_instr_kind_evt(simd_instr_kind_evt),
            .simd_to_float_evt(simd_to_float_evt),
            .float_to_simd_evt(float_to_simd_evt),
            .simd_assist_evt(simd_assist_evt),
            .simd_instr_retired_evt(simd_instr_retired_evt),
            .segment_rename_stall_evt(segment_rename_stall_evt),
            .segment_rename_count_evt(segment_rename_count_evt),
            .segment_rename_retired_evt(segment_rename_retired_evt),
            .cache_evt_valid(cache_evt_valid),
            .cache_evt_code(cache_evt_code),
            .cache_evt_state(cache_evt_state),
            .bus_evt_valid(bus_evt_valid),
            .bus_evt_code(bus_evt_code),
            .bus_evt_self(bus_evt_self),
            .inc(inc[g])
        );

        pes_counter #(.W(CW), .IW(IW)) u_ctr (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .enable(sel[SEL_EN_BIT]),
            .inc(inc[g]),
            .load(ld),
            .load_value(CW'(merge(32'(ctr[g]), wr_data, wr_strb))),
            .count(ctr[g]),
            .wrap(wrap[g])
        );
    end

    wire logic [7:0] code0 = sel_reg[0][SEL_CODE_LSB +: 8];
    wire logic [7:0] um0 = sel_reg[0][SEL_UM_LSB +: 8];
    wire logic en0 = sel_reg[0][SEL_EN_BIT];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    simd_exec_a: assert property (
        code0 == EV_SIMD_EXEC && um0 == UM_NONE && simd_move_store_evt == '0
        |-> inc[0] == IW'(simd_instr_executed_evt))
        else $error("simd executed count wrong");

    simd_sat_a: assert property (
        code0 == EV_SIMD_SAT && um0 == UM_NONE
        |-> inc[0] == IW'(simd_saturating_executed_evt))
        else $error("saturating count wrong");

    uop_mask_a: assert property (
        code0 == EV_SIMD_UOP && um0 != UM_UOP_ALL |-> inc[0] == '0)
        else $error("micro-op counted under wrong mask");

    kind_mult_a: assert property (
        code0 == EV_SIMD_KIND && um0 == 8'h01 |-> inc[0] == IW'(simd_instr_kind_evt[0]))
        else $error("multiply kind count wrong");

    trans_dir_a: assert property (
        code0 == EV_FP_TRANS && um0 == UM_TO_SIMD
        |-> inc[0] == IW'(float_to_simd_evt))
        else $error("transition direction wrong");

    assist_cnt_a: assert property (
        code0 == EV_SIMD_ASSIST && um0 == UM_NONE |-> inc[0] == IW'(simd_assist_evt))
        else $error("assist count wrong");

    retire_cnt_a: assert property (
        code0 == EV_SIMD_RET && um0 == UM_NONE
        |-> inc[0] == IW'(simd_instr_retired_evt))
        else $error("retired count wrong");

    stall_all_a: assert property (
        code0 == EV_SEG_STALL && um0 == 8'h0F
        |-> inc[0] == IW'($countones(segment_rename_stall_evt)))
        else $error("stall count over all segments wrong");

    rename_d_a: assert property (
        code0 == EV_SEG_REN && um0 == 8'h08
        |-> inc[0] == IW'(segment_rename_count_evt[3]))
        else $error("fourth segment rename count wrong");

    seg_ret_a: assert property (
        code0 == EV_SEG_RET && um0 == UM_NONE
        |-> inc[0] == IW'(segment_rename_retired_evt))
        else $error("retired rename count wrong");

    cache_zero_a: assert property (
        en0 && cache_evt_valid && cache_evt_code == code0 && um0[3:0] == 4'h0
        && !bus_evt_valid && !wr_ctr0 |=> ctr[0] == $past(ctr[0]))
        else $error("zero state mask still counted");

    bus_self_a: assert property (
        bus_evt_valid && bus_evt_code == code0 && !um0[UM_ANY_AGENT_BIT] && !bus_evt_self
        && !cache_evt_valid |-> inc[0] == '0)
        else $error("foreign bus transaction counted");

    ctr_step_a: assert property (
        en0 && !wr_ctr0 |=> ctr[0] == CW'($past(ctr[0]) + CW'($past(inc[0]))))
        else $error("counter step differs from increment");

    wr_resp_a: assert property (
        wr_go |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
        else $error("write answer late");

    rd_resp_a: assert property (
        ar_take |=> s_axi_rvalid && s_axi_rdata == $past(rd_mux))
        else $error("read answer wrong");

    exec_cv: cover property (en0 && code0 == EV_SIMD_EXEC && inc[0] != '0);
    seg_cv: cover property (en0 && code0 == EV_SEG_REN && inc[0] > IW'(1));
    wrap_cv: cover property (wrap[0] ##1 status_reg[0]);
    split_cv: cover property (aw_take && !w_take ##[1:4] w_take);
endmodule

// [include/pes_pkg.sv]
// pes_pkg: event codes, unit masks, register map and field layout
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package pes_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] EV_SIMD_EXEC = 8'hB0;
    localparam logic [7:0] EV_SIMD_SAT = 8'hB1;
    localparam logic [7:0] EV_SIMD_UOP = 8'hB2;
    localparam logic [7:0] EV_SIMD_KIND = 8'hB3;
    localparam logic [7:0] EV_FP_TRANS = 8'hCC;
    localparam logic [7:0] EV_SIMD_ASSIST = 8'hCD;
    localparam logic [7:0] EV_SIMD_RET = 8'hCE;
    localparam logic [7:0] EV_SEG_STALL = 8'hD4;
    localparam logic [7:0] EV_SEG_REN = 8'hD5;
    localparam logic [7:0] EV_SEG_RET = 8'hD6;
    localparam logic [7:0] UM_NONE = 8'h00;
    localparam logic [7:0] UM_UOP_ALL = 8'h0F;
    localparam logic [7:0] UM_TO_SIMD = 8'h01;
    localparam int UM_STATE_W = 4;
    localparam int UM_KIND_W = 6;
    localparam int UM_ANY_AGENT_BIT = 5;
    localparam logic [ADDR_W-1:0] ADDR_SEL0 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SEL1 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTR0 = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CTR1 = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_UM_LSB = 8;
    localparam int SEL_EN_BIT = 22;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTR_RESET = 32'h0000_0000;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [testbench/pes_core_model.sv]
// pes_core_model: stands in for the execution core that drives the event wires
// assumes the bench loads one cycle of events on pend and strobes go for one clock
module pes_core_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [51:0] pend,
    output logic [51:0] ev
);
    // each loaded pattern lasts exactly one cycle
    // idle wires read zero: no events happened, which is a real core state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev <= '0;
        end else begin
            ev <= go ? pend : '0;
        end
    end
endmodule

// [testbench/tb.sv]
// tb: programs selects over axi4-lite, fires one event cycle, reads the counter back
// assumes pes_top with EW=2, the core model feeding every event input
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pes_pkg::*;
    localparam int OFF[18] = '{0, 2, 4, 6, 8, 14, 15, 16, 17, 19, 23, 27, 29, 30, 38, 42, 43, 51};
    localparam int EXE = 0, STO = 1, SAT = 2, UOP = 3, KND = 4, S2F = 5, F2S = 6, AST = 7;
    localparam int RET = 8, STL = 9, REN = 10, SRT = 11, CV = 12, CC = 13, CS = 14, BV = 15;
    localparam int BC = 16, BS = 17;
    logic sys_clk;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ev_go = 1'b0;
    logic [51:0] ev_pend = '0;
    logic [51:0] ev;
    int compares = 0;
    int miscompares = 0;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    pes_core_model core (.sys_clk(sys_clk), .rst_b(rst_b), .go(ev_go), .pend(ev_pend), .ev(ev));

    pes_top #(.EW(2), .IW(4), .CW(32)) uut (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .simd_instr_executed_evt(ev[1:0]), .simd_move_store_evt(ev[3:2]),
        .simd_saturating_executed_evt(ev[5:4]), .simd_microop_executed_evt(ev[7:6]),
        .simd_instr_kind_evt(ev[13:8]), .simd_to_float_evt(ev[14]), .float_to_simd_evt(ev[15]),
        .simd_assist_evt(ev[16]), .simd_instr_retired_evt(ev[18:17]),
        .segment_rename_stall_evt(ev[22:19]), .segment_rename_count_evt(ev[26:23]),
        .segment_rename_retired_evt(ev[28:27]), .cache_evt_valid(ev[29]),
        .cache_evt_code(ev[37:30]), .cache_evt_state(ev[41:38]), .bus_evt_valid(ev[42]),
        .bus_evt_code(ev[50:43]), .bus_evt_self(ev[51])
    );

    function automatic logic [51:0] ev_at(input int i, input logic [7:0] v);
        return 52'(v) << OFF[i];
    endfunction

    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp2(input string what, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data go out together; each is dropped once its own ready is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one cycle of events reaches the design through the core model
    task automatic fire(input logic [51:0] v);
        @(posedge sys_clk);
        ev_go <= 1'b1;
        ev_pend <= v;
        @(posedge sys_clk);
        ev_go <= 1'b0;
    endtask

    // select s (0 or 1) gets code and mask, its counter is cleared, one event cycle fires
    task automatic run_case(input int s, input logic [7:0] code, input logic [7:0] mask,
                            input logic [51:0] v, input logic [31:0] exp);
        logic [1:0] r;
        logic [31:0] d;
        axi_wr(ADDR_SEL0 + 8'(4 * s),
               (32'h1 << SEL_EN_BIT) | (32'(mask) << SEL_UM_LSB) | 32'(code), r);
        cmp2("select write resp", RESP_OKAY, r);
        axi_wr(ADDR_CTR0 + 8'(4 * s), 32'h0, r);
        fire(v);
        axi_rd(ADDR_CTR0 + 8'(4 * s), d, r);
        cmp2("counter read resp", RESP_OKAY, r);
        cmp32("counter", exp, d);
        $display("case sel %0d code %h mask %h done", s, code, mask);
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a whole case takes about eleven cycles; this is several times the full run
    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [51:0] cv;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        axi_rd(ADDR_SEL0, d, r);
        cmp32("select0 reset", SEL_RESET, d);
        axi_rd(ADDR_STATUS, d, r);
        cmp32("status reset", 32'(STATUS_RESET), d);
        axi_rd(8'h14, d, r);
        cmp2("unmapped read resp", RESP_SLVERR, r);
        cmp32("unmapped read data", 32'h0, d);
        axi_wr(8'h14, 32'hFFFF_FFFF, r);
        cmp2("unmapped write resp", RESP_SLVERR, r);
        $display("register access test done");
        run_case(0, EV_SIMD_EXEC, UM_NONE, ev_at(EXE, 8'h03) | ev_at(STO, 8'h01), 32'h2);
        run_case(0, EV_SIMD_EXEC, 8'h01, ev_at(EXE, 8'h03), 32'h0);
        run_case(0, EV_SIMD_SAT, UM_NONE, ev_at(SAT, 8'h02) | ev_at(EXE, 8'h03), 32'h2);
        run_case(0, EV_SIMD_UOP, UM_UOP_ALL, ev_at(UOP, 8'h03), 32'h3);
        run_case(0, EV_SIMD_UOP, 8'h01, ev_at(UOP, 8'h03), 32'h0);
        for (int i = 0; i < 6; i++) begin
            run_case(0, EV_SIMD_KIND, 8'(1 << i), ev_at(KND, 8'h3F), 32'h1);
        end
        run_case(1, EV_SIMD_KIND, 8'h3F, ev_at(KND, 8'h2A), 32'h3);
        run_case(0, EV_FP_TRANS, UM_NONE, ev_at(S2F, 8'h01), 32'h1);
        run_case(0, EV_FP_TRANS, UM_NONE, ev_at(F2S, 8'h01), 32'h0);
        run_case(0, EV_FP_TRANS, UM_TO_SIMD, ev_at(F2S, 8'h01) | ev_at(S2F, 8'h01), 32'h1);
        run_case(0, EV_SIMD_ASSIST, UM_NONE, ev_at(AST, 8'h01), 32'h1);
        run_case(0, EV_SIMD_RET, UM_NONE, ev_at(RET, 8'h03) | ev_at(EXE, 8'h01), 32'h3);
        run_case(0, EV_SEG_STALL, 8'h0F, ev_at(STL, 8'h0F), 32'h4);
        run_case(1, EV_SEG_STALL, 8'h02, ev_at(STL, 8'h03), 32'h1);
        for (int i = 0; i < 4; i++) begin
            run_case(0, EV_SEG_REN, 8'(1 << i), ev_at(REN, 8'h0F), 32'h1);
        end
        run_case(0, EV_SEG_REN, 8'h0F, ev_at(REN, 8'h0F), 32'h4);
        run_case(0, EV_SEG_RET, UM_NONE, ev_at(SRT, 8'h02), 32'h2);
        for (int i = 0; i < 4; i++) begin
            cv = ev_at(CV, 8'h01) | ev_at(CC, 8'h2E) | ev_at(CS, 8'(1 << i));
            run_case(0, 8'h2E, 8'h0F, cv, 32'h1);
            run_case(0, 8'h2E, 8'(1 << i), cv, 32'h1);
            run_case(1, 8'h2E, 8'(4'hF ^ 4'(1 << i)), cv, 32'h0);
        end
        cv = ev_at(CV, 8'h01) | ev_at(CC, 8'h2E) | ev_at(CS, 8'h08);
        run_case(0, 8'h2E, UM_NONE, cv, 32'h0);
        run_case(0, 8'h62, 8'h00, ev_at(BV, 8'h01) | ev_at(BC, 8'h62), 32'h0);
        run_case(1, 8'h62, 8'h20, ev_at(BV, 8'h01) | ev_at(BC, 8'h62), 32'h1);
        cv = ev_at(BV, 8'h01) | ev_at(BC, 8'h62) | ev_at(BS, 8'h01);
        run_case(0, 8'h62, 8'h00, cv, 32'h1);
        run_case(0, 8'h61, 8'h20, ev_at(BV, 8'h01) | ev_at(BC, 8'h62), 32'h0);
        // select1 still counts any-agent bus events: push counter1 over the top
        axi_wr(ADDR_CTR1, 32'hFFFF_FFFF, r);
        fire(ev_at(BV, 8'h01) | ev_at(BC, 8'h62));
        axi_rd(ADDR_STATUS, d, r);
        cmp32("status after wrap", 32'h2, d);
        axi_wr(ADDR_STATUS, 32'h2, r);
        axi_rd(ADDR_STATUS, d, r);
        cmp32("status after clear", 32'h0, d);
        $display("wrap status test done");
        wrap_up();
    end
endmodule
